/* File: common/web_sensor_consts.vh */
/*
 * Constants for the web sensor status and position block: word layout,
 * process data map indices, pixel count tables and controller states.
 * Assumes it is included by bare name from files that need it.
 */
`ifndef WEB_SENSOR_CONSTS_VH
`define WEB_SENSOR_CONSTS_VH

// ****************************************
// status and fault word layout
// ****************************************
`define SFW_NO_SENSOR     0
`define SFW_LOW_CONTRAST  1
`define SFW_NO_WEB        2
`define SFW_WRONG_ORIENT  3
`define SFW_RSVD_A        4
`define SFW_FLUTTER       5
`define SFW_RSVD_B        6
`define SFW_FAMILY        7
`define SFW_LEFT          8
`define SFW_RIGHT         9
`define SFW_CODE_LSB      10
`define SFW_CODE_MSB      13
`define SFW_MODE_LSB      14
`define SFW_MODE_MSB      15

// ****************************************
// process data map (word index)
// ****************************************
`define MAP_STATUS_BASE   3'h0
`define MAP_POS_BASE      3'h2
`define MAP_SENSOR_STRIDE 3'h3
`define MAP_WORDS         8
`define MAP_IDX_W         3
`define WORDS_PER_SENSOR  2'h3

// ****************************************
// pixel counts, first family
// ****************************************
`define PXN_F0_C0         16'h0100
`define PXN_F0_C1         16'h0300
`define PXN_F0_C2         16'h06EE
`define PXN_F0_C3         16'h0380
`define PXN_F0_C5         16'h0700
`define PXN_F0_C6         16'h06EC
`define PXN_F0_C7         16'h0DD8
`define PXN_F0_C8         16'h0DE2

// ****************************************
// pixel counts, second family
// ****************************************
`define PXN_F1_C1         16'h02F8
`define PXN_F1_C2         16'h02FC
`define PXN_F1_C3         16'h0600
`define PXN_F1_C4         16'h05F6
`define PXN_F1_C5         16'h0BEC
`define PXN_F1_C8         16'h0BE2
`define PXN_F1_C12        16'h17BA
`define PXN_UNDEF         16'h0000

// ****************************************
// map writer states and misc
// ****************************************
`define ST_CLEAR          2'h0
`define ST_IDLE           2'h1
`define ST_WRITE          2'h2
`define MODE_EDGE         1'h0
`define WORD_ZERO         16'h0000
`define PIN_BITS          11

`endif

/* File: src/line_edge_scan.v */
/*
 * Scans one captured image line of covered/open pixels, left to right.
 * Assumes pixels arrive on the same clock, one per pix_valid, with
 * pix_last on the final pixel of the line.
 */
`timescale 1ns/1ps
module line_edge_scan #(
	parameter POS_W = 16
) (
	input  wire             clock,
	input  wire             sys_rst,
	input  wire             pix_valid,
	input  wire             pix_covered,
	input  wire             pix_last,
	output reg              done,
	output reg  [POS_W-1:0] first_cov,
	output reg  [POS_W-1:0] end_cov,
	output reg  [POS_W-1:0] cov_sum,
	output reg              any_cov,
	output reg              first_px,
	output reg              last_px
);
	reg [POS_W-1:0] idx_r;
	reg [POS_W-1:0] first_r;
	reg [POS_W-1:0] end_r;
	reg [POS_W-1:0] sum_r;
	reg             seen_r;
	reg             px0_r;
	reg [POS_W-1:0] first_nxt;
	reg [POS_W-1:0] end_nxt;
	reg [POS_W-1:0] sum_nxt;
	reg             seen_nxt;
	reg             in_span_nxt;

	// ****************************************
	// per pixel accumulation
	// ****************************************
	always @* begin
		first_nxt   = first_r;
		end_nxt     = end_r;
		sum_nxt     = sum_r;
		seen_nxt    = seen_r;
		// the line starts open, so a covered first pixel is a rising edge
		in_span_nxt = pix_covered;
		if (pix_covered && !seen_r) begin
			seen_nxt  = 1'b1;
			first_nxt = idx_r;
		end
		if (pix_covered) begin
			end_nxt = idx_r + {{(POS_W-1){1'b0}}, 1'b1};
		end
		if (in_span_nxt) begin
			sum_nxt = sum_r + {{(POS_W-1){1'b0}}, 1'b1}; // see RULE_19 see RULE_20
		end
	end

	always @(posedge clock) begin
		if (sys_rst) begin
			idx_r     <= {POS_W{1'b0}};
			first_r   <= {POS_W{1'b0}};
			end_r     <= {POS_W{1'b0}};
			sum_r     <= {POS_W{1'b0}};
			seen_r    <= 1'b0;
			px0_r     <= 1'b0;
			done      <= 1'b0;
			first_cov <= {POS_W{1'b0}};
			end_cov   <= {POS_W{1'b0}};
			cov_sum   <= {POS_W{1'b0}};
			any_cov   <= 1'b0;
			first_px  <= 1'b0;
			last_px   <= 1'b0;
		end else begin
			done <= 1'b0;
			if (pix_valid) begin
				if (pix_last) begin
					// raw line result, no filtering, see RULE_21
					done      <= 1'b1;
					first_cov <= first_nxt;
					end_cov   <= end_nxt;
					cov_sum   <= sum_nxt;
					any_cov   <= seen_nxt;
					first_px  <= (idx_r == {POS_W{1'b0}}) ? pix_covered : px0_r;
					last_px   <= pix_covered;
					idx_r     <= {POS_W{1'b0}};
					first_r   <= {POS_W{1'b0}};
					end_r     <= {POS_W{1'b0}};
					sum_r     <= {POS_W{1'b0}};
					seen_r    <= 1'b0;
				end else begin
					if (idx_r == {POS_W{1'b0}}) begin
						px0_r <= pix_covered;
					end
					idx_r   <= idx_r + {{(POS_W-1){1'b0}}, 1'b1};
					first_r <= first_nxt;
					end_r   <= end_nxt;
					sum_r   <= sum_nxt;
					seen_r  <= seen_nxt;
				end
			end
		end
	end
endmodule

/* File: src/web_sensor_status_position.v */
/*
 * Status, fault, edge position and coverage words for two line-scan web
 * edge sensors, kept in an eight word map read by the process data side.
 * Assumes pixel streams come from readout logic on this clock; status and
 * configuration levels arrive from pins and are synchronised here.
 */
// What this block does
// RULE_01 - low byte of status word holds faults, high byte configuration and status
// RULE_02 - bit 0 set when no sensor attached, clear when present
// RULE_03 - bit 1 set on low measured contrast, clear on high contrast
// RULE_04 - bit 2 set when no web is detected, clear otherwise
// RULE_05 - bit 3 set when an edge opposes the configured orientation
// RULE_06 - bits 4 and 6 are reserved without meaning
// RULE_07 - bit 5 set when flutter or out-of-plane motion is seen
// RULE_08 - bit 7 gives sensor family, 0 first family, 1 second family
// RULE_09 - bit 8 marks left sensor, bit 9 marks right sensor
// RULE_10 - centre sensor shows both left and right bits set
// RULE_11 - bits 10-13 hold pixel count code, table chosen by bit 7
// RULE_12 - bits 14-15 hold sensing mode, 0 edge, 1 contrast position
// RULE_13 - edge mode gives left edge; right-configured sensor reads zero
// RULE_14 - right word gives right edge in edge mode, contrast position otherwise
// RULE_15 - contrast mode with no contrast loads total pixel count
// RULE_16 - positions grow as the web moves left to right, either orientation
// RULE_17 - open gives pixel count for left, 0 for right; covered reverses
// RULE_18 - reader ignores positions while no-sensor or no-web is set
// RULE_19 - coverage is the sum of individual web widths
// RULE_20 - each width spans from one rising edge to the next; code counts covered pixels up to each falling edge
// RULE_21 - coverage is raw and instantaneous, unaffected by any filter
// RULE_22 - each sensor has its own status word, index 0 and index 1
// RULE_23 - reserved bits and undefined pixel codes read as zero
`timescale 1ns/1ps
`include "web_sensor_consts.vh"
module web_sensor_status_position #(
	parameter POS_W = 16
) (
	input  wire                   clock,
	input  wire                   sys_rst,
	input  wire [1:0]             sensor_absent,
	input  wire [1:0]             low_contrast,
	input  wire [1:0]             flutter_seen,
	input  wire [1:0]             sensor_family_select,
	input  wire [1:0]             cfg_left,
	input  wire [1:0]             cfg_right,
	input  wire [7:0]             pixel_code,
	input  wire [1:0]             contrast_mode,
	input  wire [1:0]             pix_valid,
	input  wire [1:0]             pix_covered,
	input  wire [1:0]             pix_last,
	input  wire                   rd_en,
	input  wire [`MAP_IDX_W-1:0]  rd_index,
	output wire [POS_W-1:0]       rd_data,
	output reg                    rd_valid,
	output reg                    map_ready,
	output reg  [1:0]             line_update
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	wire [2*`PIN_BITS-1:0] pin_raw;
	reg  [2*`PIN_BITS-1:0] pin_s1_r;
	reg  [2*`PIN_BITS-1:0] pin_s2_r;
	reg  [2*`PIN_BITS-1:0] pin_s3_r;
	reg  [2*`PIN_BITS-1:0] pin_q_r;

	assign pin_raw = {contrast_mode, pixel_code, cfg_right, cfg_left,
		sensor_family_select, flutter_seen, low_contrast, sensor_absent};

	genvar gb;
	generate
		for (gb = 0; gb < 2*`PIN_BITS; gb = gb + 1) begin : g_sync
			// a level only counts once stages two and three agree
			always @(posedge clock) begin
				if (sys_rst) begin
					pin_s1_r[gb] <= 1'b0;
					pin_s2_r[gb] <= 1'b0;
					pin_s3_r[gb] <= 1'b0;
					pin_q_r[gb]  <= 1'b0;
				end else begin
					pin_s1_r[gb] <= pin_raw[gb];
					pin_s2_r[gb] <= pin_s1_r[gb];
					pin_s3_r[gb] <= pin_s2_r[gb];
					if (pin_s2_r[gb] == pin_s3_r[gb]) begin
						pin_q_r[gb] <= pin_s3_r[gb];
					end
				end
			end
		end
	endgenerate

	wire [1:0] q_absent   = pin_q_r[1:0];
	wire [1:0] q_lowcon   = pin_q_r[3:2];
	wire [1:0] q_flutter  = pin_q_r[5:4];
	wire [1:0] q_family   = pin_q_r[7:6];
	wire [1:0] q_left     = pin_q_r[9:8];
	wire [1:0] q_right    = pin_q_r[11:10];
	wire [7:0] q_code     = pin_q_r[19:12];
	wire [1:0] q_contrast = pin_q_r[21:20];

	// ****************************************
	// pixel count tables
	// ****************************************
	function [POS_W-1:0] pixel_total;
		input       fam;
		input [3:0] code;
		reg   [15:0] n;
		begin
			n = `PXN_UNDEF; // see RULE_23
			if (!fam) begin
				case (code)
					4'h0: n = `PXN_F0_C0;
					4'h1: n = `PXN_F0_C1;
					4'h2: n = `PXN_F0_C2;
					4'h3: n = `PXN_F0_C3;
					4'h5: n = `PXN_F0_C5;
					4'h6: n = `PXN_F0_C6;
					4'h7: n = `PXN_F0_C7;
					4'h8: n = `PXN_F0_C8;
					default: n = `PXN_UNDEF;
				endcase
			end else begin
				case (code)
					4'h1: n = `PXN_F1_C1;
					4'h2: n = `PXN_F1_C2;
					4'h3: n = `PXN_F1_C3;
					4'h4: n = `PXN_F1_C4;
					4'h5: n = `PXN_F1_C5;
					4'h8: n = `PXN_F1_C8;
					4'hC: n = `PXN_F1_C12;
					default: n = `PXN_UNDEF;
				endcase
			end
			pixel_total = n[POS_W-1:0]; // see RULE_11
		end
	endfunction

	// ****************************************
	// line scanners and per sensor snapshots
	// ****************************************
	wire [1:0]       scan_done;
	wire [POS_W-1:0] scan_first [0:1];
	wire [POS_W-1:0] scan_end   [0:1];
	wire [POS_W-1:0] scan_sum   [0:1];
	wire [1:0]       scan_any;
	wire [1:0]       scan_px0;
	wire [1:0]       scan_pxl;

	reg  [15:0]      status_r [0:1];
	reg  [POS_W-1:0] left_r   [0:1];
	reg  [POS_W-1:0] right_r  [0:1];
	reg  [POS_W-1:0] cover_r  [0:1];

	genvar gs;
	generate
		for (gs = 0; gs < 2; gs = gs + 1) begin : g_sensor
			wire [3:0]       code_w  = q_code[4*gs+3:4*gs];
			wire [POS_W-1:0] total_w = pixel_total(q_family[gs], code_w);
			wire             edge_w  = (q_contrast[gs] == `MODE_EDGE);
			wire             left_only  = q_left[gs] & ~q_right[gs];
			wire             right_only = q_right[gs] & ~q_left[gs];
			wire             wrong_w;
			wire [15:0]      status_w;
			wire [POS_W-1:0] left_w;
			wire [POS_W-1:0] right_w;

			line_edge_scan #(
				.POS_W       (POS_W)
			) u_scan (
				.clock       (clock),
				.sys_rst     (sys_rst),
				.pix_valid   (pix_valid[gs]),
				.pix_covered (pix_covered[gs]),
				.pix_last    (pix_last[gs]),
				.done        (scan_done[gs]),
				.first_cov   (scan_first[gs]),
				.end_cov     (scan_end[gs]),
				.cov_sum     (scan_sum[gs]),
				.any_cov     (scan_any[gs]),
				.first_px    (scan_px0[gs]),
				.last_px     (scan_pxl[gs])
			);

			// a left sensor expects open on the left and web to the right
			assign wrong_w = edge_w & scan_any[gs] &
				((left_only & scan_px0[gs] & ~scan_pxl[gs]) |
				(right_only & ~scan_px0[gs] & scan_pxl[gs])); // see RULE_05

			assign status_w[`SFW_NO_SENSOR]    = q_absent[gs];      // see RULE_02
			assign status_w[`SFW_LOW_CONTRAST] = q_lowcon[gs];      // see RULE_03
			assign status_w[`SFW_NO_WEB]       = ~scan_any[gs];     // see RULE_04
			assign status_w[`SFW_WRONG_ORIENT] = wrong_w;
			assign status_w[`SFW_RSVD_A]       = 1'b0;              // see RULE_06
			assign status_w[`SFW_FLUTTER]      = q_flutter[gs];     // see RULE_07
			assign status_w[`SFW_RSVD_B]       = 1'b0;              // see RULE_06
			assign status_w[`SFW_FAMILY]       = q_family[gs];      // see RULE_08
			// high byte is configuration, low byte faults, see RULE_01
			assign status_w[`SFW_LEFT]         = q_left[gs];        // see RULE_09 see RULE_10
			assign status_w[`SFW_RIGHT]        = q_right[gs];       // see RULE_09 see RULE_10
			assign status_w[`SFW_CODE_MSB:`SFW_CODE_LSB] = code_w;  // see RULE_11
			assign status_w[`SFW_MODE_MSB:`SFW_MODE_LSB] =
				{1'b0, q_contrast[gs]};                             // see RULE_12

			// pixel indices grow left to right for both orientations, see RULE_16
			// edge mode, open: left gives total (0 if right only), right gives 0; covered reverses, see RULE_17
			assign left_w = (!edge_w || right_only) ? {POS_W{1'b0}} :
				(scan_any[gs] ? scan_first[gs] : total_w);          // see RULE_13
			assign right_w = edge_w ?
				(scan_any[gs] ? scan_end[gs] : {POS_W{1'b0}}) :     // see RULE_14
				(scan_any[gs] ? scan_first[gs] : total_w);          // see RULE_15

			// snapshot taken with the line so words of one sensor agree
			always @(posedge clock) begin
				if (sys_rst) begin
					status_r[gs] <= `WORD_ZERO;
					left_r[gs]   <= {POS_W{1'b0}};
					right_r[gs]  <= {POS_W{1'b0}};
					cover_r[gs]  <= {POS_W{1'b0}};
				end else if (scan_done[gs]) begin
					status_r[gs] <= status_w;
					left_r[gs]   <= left_w;
					right_r[gs]  <= right_w;
					cover_r[gs]  <= scan_sum[gs];                   // see RULE_21
				end
			end
		end
	endgenerate

	// ****************************************
	// map writer
	// ****************************************
	reg [1:0]              state_r;
	reg [1:0]              state_nxt;
	reg [1:0]              pend_r;
	reg [1:0]              pend_nxt;
	reg                    sel_r;
	reg                    sel_nxt;
	reg [1:0]              widx_r;
	reg [1:0]              widx_nxt;
	reg [`MAP_IDX_W-1:0]   clr_r;
	reg [`MAP_IDX_W-1:0]   clr_nxt;
	reg [15:0]             wbuf_r [0:3];
	reg                    load_buf;
	reg                    wr_en;
	reg [`MAP_IDX_W-1:0]   wr_addr;
	reg [15:0]             wr_data;

	wire [`MAP_IDX_W-1:0] clr_last = {`MAP_IDX_W{1'b1}};

	always @* begin
		state_nxt = state_r;
		pend_nxt  = pend_r;
		sel_nxt   = sel_r;
		widx_nxt  = widx_r;
		clr_nxt   = clr_r;
		load_buf  = 1'b0;
		wr_en     = 1'b0;
		wr_addr   = {`MAP_IDX_W{1'b0}};
		wr_data   = `WORD_ZERO;
		case (state_r)
			`ST_CLEAR: begin
				// every word reads zero until its first line arrives
				wr_en   = 1'b1;
				wr_addr = clr_r;
				clr_nxt = clr_r + {{(`MAP_IDX_W-1){1'b0}}, 1'b1};
				if (clr_r == clr_last) begin
					state_nxt = `ST_IDLE;
				end
			end
			`ST_IDLE: begin
				if (pend_r != 2'b00) begin
					sel_nxt   = ~pend_r[0];
					load_buf  = 1'b1;
					pend_nxt[~pend_r[0]] = 1'b0;
					widx_nxt  = 2'b00;
					state_nxt = `ST_WRITE;
				end
			end
			`ST_WRITE: begin
				wr_en    = 1'b1;
				wr_data  = wbuf_r[widx_r];
				// status words sit at index 0 and 1, see RULE_22
				if (widx_r == 2'b00) begin
					wr_addr = `MAP_STATUS_BASE + {2'b00, sel_r};
				end else begin
					wr_addr = `MAP_POS_BASE + (sel_r ? `MAP_SENSOR_STRIDE : 3'h0)
						+ {1'b0, widx_r - 2'b01};
				end
				widx_nxt = widx_r + 2'b01;
				if (widx_r == `WORDS_PER_SENSOR) begin
					state_nxt = `ST_IDLE;
				end
			end
			default: begin
				state_nxt = `ST_CLEAR;
				clr_nxt   = {`MAP_IDX_W{1'b0}};
			end
		endcase
		// a new line wins over the clear made when its sensor is taken
		pend_nxt = pend_nxt | scan_done;
	end

	integer k;
	always @(posedge clock) begin
		if (sys_rst) begin
			state_r     <= `ST_CLEAR;
			pend_r      <= 2'b00;
			sel_r       <= 1'b0;
			widx_r      <= 2'b00;
			clr_r       <= {`MAP_IDX_W{1'b0}};
			rd_valid    <= 1'b0;
			map_ready   <= 1'b0;
			line_update <= 2'b00;
			for (k = 0; k < 4; k = k + 1) begin
				wbuf_r[k] <= `WORD_ZERO;
			end
		end else begin
			state_r     <= state_nxt;
			pend_r      <= pend_nxt;
			sel_r       <= sel_nxt;
			widx_r      <= widx_nxt;
			clr_r       <= clr_nxt;
			rd_valid    <= rd_en;
			map_ready   <= (state_nxt != `ST_CLEAR);
			line_update <= 2'b00;
			if (load_buf) begin
				wbuf_r[0] <= status_r[sel_nxt];
				wbuf_r[1] <= left_r[sel_nxt];
				wbuf_r[2] <= right_r[sel_nxt];
				wbuf_r[3] <= cover_r[sel_nxt];
			end
			if (state_r == `ST_WRITE && widx_r == `WORDS_PER_SENSOR) begin
				line_update[sel_r] <= 1'b1;
			end
		end
	end

	// ****************************************
	// word map
	// ****************************************
	word_map_ram #(
		.WIDTH   (POS_W),
		.DEPTH   (`MAP_WORDS),
		.AW      (`MAP_IDX_W)
	) u_map (
		.clock   (clock),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_en   (rd_en),
		.rd_addr (rd_index),
		.rd_data (rd_data)
	);

endmodule

/* File: src/word_map_ram.v */
/*
 * Small word memory holding the readable process data map.
 * Assumes one writer and one reader on the same clock; read data are
 * registered and appear one clock after the read strobe.
 */
`timescale 1ns/1ps
module word_map_ram #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clock,
	input  wire             wr_en,
	input  wire [AW-1:0]    wr_addr,
	input  wire [WIDTH-1:0] wr_data,
	input  wire             rd_en,
	input  wire [AW-1:0]    rd_addr,
	output reg  [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];

	// no reset here: the owner clears every word after reset
	always @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

/* File: testbench/plc_reader_model.sv */
/*
 * Process data reader standing in for the controller side: one word per read.
 * Assumes the block answers one cycle after the read strobe is taken.
 */
`timescale 1ns/1ps
module plc_reader_model (
	input  wire        clock,
	input  wire [15:0] rd_data,
	input  wire        rd_valid,
	output reg         rd_en,
	output reg  [2:0]  rd_index,
	output reg         pos_usable
);
	initial begin
		rd_en = 1'b0;
		rd_index = 3'h0;
		pos_usable = 1'b0;
	end

	task read_word(input [2:0] idx, output [15:0] d, output ok);
		integer n;
		begin
			ok = 1'b0;
			d = 16'h0000;
			@(posedge clock);
			rd_en <= 1'b1;
			rd_index <= idx;
			@(posedge clock);
			rd_en <= 1'b0;
			// released index never keeps the last value
			rd_index <= ~idx;
			for (n = 0; n < 4 && !ok; n = n + 1) begin
				@(posedge clock);
				if (rd_valid === 1'b1) begin
					ok = 1'b1;
					d = rd_data;
				end
			end
			// positions trusted only with sensor and web present
			if (ok && idx < 3'h2)
				pos_usable <= !d[0] && !d[2];
		end
	endtask
endmodule

/* File: testbench/tb_web_sensor_status_position.sv */
/*
 * Self-checking bench: table of lines per sensor, code sweep, both sensors
 * at once and a second reset at the end. Assumes the reader model and the checker.
 */
`timescale 1ns/1ps
module tb_web_sensor_status_position;
	typedef struct packed {
		logic        s;
		logic        fam;
		logic        lft;
		logic        rgt;
		logic [3:0]  code;
		logic        mode;
		logic [2:0]  flt;
		logic [4:0]  len;
		logic [15:0] pat;
	} row_t;
	reg          clock, sys_rst;
	reg  [1:0]   sensor_absent, low_contrast, flutter_seen, sensor_family_select;
	reg  [1:0]   cfg_left, cfg_right, contrast_mode, pix_valid, pix_covered, pix_last;
	reg  [7:0]   pixel_code;
	wire [15:0]  rd_data;
	wire         rd_valid, map_ready, rd_en, pos_usable;
	wire [1:0]   line_update;
	wire [2:0]   rd_index;
	integer      error_cnt, checked, i;
	row_t        rows [0:12];
	row_t        x;
	logic [15:0] w;
	logic        ok;

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	web_sensor_status_position dut (.clock(clock), .sys_rst(sys_rst),
		.sensor_absent(sensor_absent), .low_contrast(low_contrast),
		.flutter_seen(flutter_seen), .sensor_family_select(sensor_family_select),
		.cfg_left(cfg_left), .cfg_right(cfg_right), .pixel_code(pixel_code),
		.contrast_mode(contrast_mode), .pix_valid(pix_valid), .pix_covered(pix_covered),
		.pix_last(pix_last), .rd_en(rd_en), .rd_index(rd_index), .rd_data(rd_data),
		.rd_valid(rd_valid), .map_ready(map_ready), .line_update(line_update));
	plc_reader_model rdr (.clock(clock), .rd_data(rd_data), .rd_valid(rd_valid),
		.rd_en(rd_en), .rd_index(rd_index), .pos_usable(pos_usable));

	// ****************************************
	// helpers
	// ****************************************
	task end_sim;
		begin
			$display("comparisons %0d mismatches %0d", checked, error_cnt);
			if (error_cnt == 0 && checked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	task check(input [15:0] seen, input [15:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask

	task timed_out;
		begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED at %0t: wait ran out", $time);
			end_sim;
		end
	endtask

	task rd(input [2:0] idx, input [15:0] exp);
		begin
			rdr.read_word(idx, w, ok);
			if (ok !== 1'b1)
				timed_out;
			check(w, exp);
		end
	endtask

	function [15:0] npix(input f, input [3:0] c);
		case ({f, c})
			5'h00: npix = 16'h0100;
			5'h01: npix = 16'h0300;
			5'h02: npix = 16'h06EE;
			5'h03: npix = 16'h0380;
			5'h05: npix = 16'h0700;
			5'h06: npix = 16'h06EC;
			5'h07: npix = 16'h0DD8;
			5'h08: npix = 16'h0DE2;
			5'h11: npix = 16'h02F8;
			5'h12: npix = 16'h02FC;
			5'h13: npix = 16'h0600;
			5'h14: npix = 16'h05F6;
			5'h15: npix = 16'h0BEC;
			5'h18: npix = 16'h0BE2;
			5'h1C: npix = 16'h17BA;
			default: npix = 16'h0000;
		endcase
	endfunction

	task do_reset;
		integer k;
		begin
			@(posedge clock);
			sys_rst <= 1'b1;
			repeat (3) @(posedge clock);
			sys_rst <= 1'b0;
			check({15'h0000, map_ready}, 16'h0000);
			for (k = 0; k < 20 && map_ready !== 1'b1; k = k + 1)
				@(posedge clock);
			if (map_ready !== 1'b1)
				timed_out;
			for (k = 0; k < 8; k = k + 1)
				rd(k[2:0], 16'h0000);
		end
	endtask

	task set_pins(input row_t r);
		begin
			@(posedge clock);
			sensor_absent[r.s] <= r.flt[2];
			low_contrast[r.s] <= r.flt[1];
			flutter_seen[r.s] <= r.flt[0];
			sensor_family_select[r.s] <= r.fam;
			cfg_left[r.s] <= r.lft;
			cfg_right[r.s] <= r.rgt;
			contrast_mode[r.s] <= r.mode;
			pixel_code[4*r.s +: 4] <= r.code;
			// synchronisers need a few clocks before the pins are seen
			repeat (6) @(posedge clock);
		end
	endtask

	task send_line(input [1:0] m, input [4:0] len, input [15:0] pat);
		integer k;
		logic [1:0] seen;
		begin
			for (k = 0; k < len; k = k + 1) begin
				@(posedge clock);
				pix_valid <= m;
				pix_covered <= {2{pat[k]}};
				pix_last <= (k == len - 1) ? m : 2'b00;
			end
			@(posedge clock);
			pix_valid <= 2'b00;
			pix_last <= 2'b00;
			pix_covered <= ~pix_covered;
			seen = 2'b00;
			for (k = 0; k < 20 && seen !== m; k = k + 1) begin
				@(posedge clock);
				seen = seen | line_update;
			end
			if (seen !== m)
				timed_out;
		end
	endtask

	task verify(input row_t r);
		integer k;
		logic [15:0] f, e, c, n, st, lw, rw;
		logic wr;
		logic [2:0] p;
		begin
			f = 16'h0000;
			e = 16'h0000;
			c = 16'h0000;
			for (k = r.len - 1; k >= 0; k = k - 1)
				if (r.pat[k]) begin
					f = k[15:0];
					c = c + 16'h0001;
					if (e == 16'h0000)
						e = k[15:0] + 16'h0001;
				end
			n = npix(r.fam, r.code);
			wr = !r.mode && ((r.lft && !r.rgt && r.pat[0] && !r.pat[r.len-1])
				|| (r.rgt && !r.lft && !r.pat[0] && r.pat[r.len-1]));
			st = {1'b0, r.mode, r.code, r.rgt, r.lft, r.fam, 1'b0, r.flt[0], 1'b0, wr,
				c == 16'h0000, r.flt[1], r.flt[2]};
			lw = (r.mode || (r.rgt && !r.lft)) ? 16'h0000 : (c != 16'h0000 ? f : n);
			rw = r.mode ? (c != 16'h0000 ? f : n) : (c != 16'h0000 ? e : 16'h0000);
			p = r.s ? 3'h5 : 3'h2;
			rd({2'b00, r.s}, st);
			rd(p, lw);
			check({15'h0, pos_usable}, {15'h0, !r.flt[2] && c != 0});
			rd(p + 3'h1, rw);
			rd(p + 3'h2, c);
		end
	endtask

	task run_row(input row_t r);
		begin
			set_pins(r);
			send_line(r.s ? 2'b10 : 2'b01, r.len, r.pat);
			verify(r);
		end
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		error_cnt = 0;
		checked = 0;
		sys_rst = 1'b1;
		{sensor_absent, low_contrast, flutter_seen, sensor_family_select} = 8'h00;
		{cfg_left, cfg_right, contrast_mode, pix_valid, pix_covered, pix_last} = 12'h000;
		pixel_code = 8'h00;
		// s fam left right code mode faults len pattern; rows 0 and 1 move the web right
		rows[0] = {4'b0010, 4'h0, 1'b0, 3'h0, 5'h08, 16'h00F0};
		rows[1] = {4'b0010, 4'h0, 1'b0, 3'h0, 5'h08, 16'h00E0};
		rows[2] = {4'b1101, 4'h3, 1'b0, 3'h0, 5'h08, 16'h000F};
		rows[3] = {4'b1101, 4'h3, 1'b0, 3'h0, 5'h08, 16'h00F0};
		rows[4] = {4'b0010, 4'h1, 1'b0, 3'h7, 5'h08, 16'h000F};
		rows[5] = {4'b0010, 4'h5, 1'b0, 3'h0, 5'h08, 16'h0000};
		rows[6] = {4'b1101, 4'h2, 1'b0, 3'h0, 5'h08, 16'h0000};
		rows[7] = {4'b0010, 4'h8, 1'b0, 3'h0, 5'h08, 16'h00FF};
		rows[8] = {4'b1101, 4'h8, 1'b0, 3'h0, 5'h08, 16'h00FF};
		rows[9] = {4'b0011, 4'h7, 1'b0, 3'h2, 5'h0C, 16'h0666};
		rows[10] = {4'b1111, 4'hC, 1'b1, 3'h1, 5'h08, 16'h0030};
		rows[11] = {4'b0010, 4'h6, 1'b0, 3'h0, 5'h01, 16'h0001};
		rows[12] = {4'b1011, 4'h4, 1'b0, 3'h4, 5'h10, 16'hF00F};
		do_reset;
		for (i = 0; i < 13; i = i + 1)
			run_row(rows[i]);
		// every code of both families, contrast mode with nothing seen
		for (i = 0; i < 32; i = i + 1)
			run_row({1'b0, i[4], 2'b10, i[3:0], 1'b1, 3'h0, 5'h04, 16'h0000});
		// both sensors finish a line together
		x = rows[9];
		x.s = 1'b1;
		x.fam = 1'b1;
		set_pins(rows[9]);
		set_pins(x);
		send_line(2'b11, x.len, x.pat);
		verify(rows[9]);
		verify(x);
		do_reset;
		end_sim;
	end
endmodule

/* File: testbench/web_sensor_status_position_sva.sv */
/*
 * Checker for the web sensor status and position block: read port timing,
 * map readiness after reset, line update pulses and reserved status bits.
 * Assumes it is bound to the block's top module and sees only its ports.
 */
`timescale 1ns/1ps
module web_sensor_status_position_sva #(
	parameter POS_W = 16
) (
	input wire             clock,
	input wire             sys_rst,
	input wire [1:0]       pix_valid,
	input wire [1:0]       pix_last,
	input wire             rd_en,
	input wire [2:0]       rd_index,
	input wire [POS_W-1:0] rd_data,
	input wire             rd_valid,
	input wire             map_ready,
	input wire [1:0]       line_update
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	// ****************************************
	// sequences
	// ****************************************
	sequence rd_req;
		rd_en;
	endsequence
	sequence rd_ans;
		rd_valid;
	endsequence
	sequence status_rd;
		rd_en && map_ready && rd_index < 3'h2;
	endsequence

	// ****************************************
	// assertions
	// ****************************************
	chk_read_answer: assert property (rd_req |=> rd_ans)
		else $error("read not answered on the next cycle");
	chk_no_stray_valid: assert property (!rd_en |=> !rd_valid)
		else $error("read valid without a read");
	chk_data_holds: assert property (!rd_en |=> $stable(rd_data))
		else $error("read data changed without a read");
	chk_ready_rise: assert property ($fell(sys_rst) |-> !map_ready ##[1:9] map_ready)
		else $error("map not ready in time after reset");
	chk_ready_stays: assert property (map_ready |=> map_ready)
		else $error("map ready dropped");
	chk_update_pulse: assert property (line_update[0] |=> !line_update[0])
		else $error("line update longer than one cycle");
	chk_update_onehot: assert property ($onehot0(line_update))
		else $error("both sensors updated together");
	chk_reserved_zero: assert property (status_rd |=> rd_data[4] == 1'b0 && rd_data[6] == 1'b0
		&& rd_data[15] == 1'b0)
		else $error("reserved status bit set");
	chk_line_written: assert property (map_ready && pix_valid[1] && pix_last[1]
		|-> ##[5:14] line_update[1])
		else $error("second sensor line not written in time");
endmodule

bind web_sensor_status_position web_sensor_status_position_sva #(.POS_W(POS_W)) u_chk (
	.clock(clock), .sys_rst(sys_rst), .pix_valid(pix_valid), .pix_last(pix_last),
	.rd_en(rd_en), .rd_index(rd_index), .rd_data(rd_data), .rd_valid(rd_valid),
	.map_ready(map_ready), .line_update(line_update)
);
